// ===== include/can_test_pkg.sv
// Constants, field layout and state type of the CAN channel test-mode block.
// Assumes one 10 MHz system clock and a 32-bit word-per-register port.
package can_test_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ         = 10_000_000;
	localparam int unsigned MODE_SWITCH_TIME_NS = 400;
	localparam int unsigned MODE_SWITCH_CYCLES  =
		(MODE_SWITCH_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

	// ---------------------------------------------------------------
	// Register offsets and fields
	// ---------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_ERR_FLAG    = 8'h08;
	localparam logic [7:0]  OFS_FD_CRC      = 8'h0C;
	localparam int unsigned CTRL_MODE_LSB   = 0;
	localparam int unsigned CTRL_SLEEP_BIT  = 2;
	localparam int unsigned CTRL_TMS_LSB    = 16;
	localparam int unsigned CTRL_CTE_BIT    = 18;
	localparam int unsigned CTRL_INTER_BIT  = 19;
	localparam int unsigned CTRL_MIRROR_BIT = 20;
	localparam int unsigned STS_MODE_LSB    = 0;
	localparam int unsigned STS_SLEEP_BIT   = 2;
	localparam int unsigned CRC_CLASSIC_W   = 15;
	localparam int unsigned CRC_FD_W        = 21;

	// ---------------------------------------------------------------
	// Codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  MODE_COMM       = 2'h0;
	localparam logic [1:0]  MODE_RESET      = 2'h1;
	localparam logic [1:0]  MODE_HALT       = 2'h2;
	localparam logic [1:0]  TMS_STANDARD    = 2'h0;
	localparam logic [1:0]  TMS_LISTEN      = 2'h1;
	localparam logic [1:0]  TMS_SELF0       = 2'h2;
	localparam logic [1:0]  TMS_SELF1       = 2'h3;
	localparam logic [1:0]  MODE_RESET_VAL  = MODE_RESET;
	localparam logic [1:0]  TMS_RESET_VAL   = TMS_STANDARD;
	localparam logic        RECESSIVE       = 1'b1;
	localparam logic        DOMINANT        = 1'b0;

	typedef enum logic [1:0] {ST_RESET, ST_HALT, ST_COMM, ST_SLEEP} chan_state_type;

endpackage : can_test_pkg

// ===== include/test_ctrl_if.sv
// Test settings shared by the channel controller and its helpers.
// Assumes all parties run on sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface test_ctrl_if;
	logic comm_test_enable;
	logic self_test;
	logic mirror_enable;
	modport source (output comm_test_enable, output self_test, output mirror_enable);
	modport sink   (input comm_test_enable, input self_test, input mirror_enable);
endinterface : test_ctrl_if
`default_nettype wire

// ===== logic/crc_capture.sv
// Holds the CRC of the latest frame, classical and FD apart.
// Assumes crc_done is a one-cycle pulse from the protocol core.
`timescale 1ns/100ps
`default_nettype none
module crc_capture (
	input  wire logic                                  sys_clk,
	input  wire logic                                  rst,
	test_ctrl_if.sink                                  ctrl,
	input  wire logic                                  crc_done,
	input  wire logic                                  crc_is_fd,
	input  wire logic [can_test_pkg::CRC_FD_W-1:0]     crc_value,
	output logic      [can_test_pkg::CRC_CLASSIC_W-1:0] classic_crc,
	output logic      [can_test_pkg::CRC_FD_W-1:0]     fd_crc
);
	// Cleared while testing is off so stale values never leak
	always_ff @(posedge sys_clk) begin
		if (rst || !ctrl.comm_test_enable) begin
			classic_crc <= '0;
			fd_crc      <= '0;
		end else if (crc_done) begin
			if (crc_is_fd) begin
				fd_crc <= crc_value;
			end else begin
				classic_crc <= crc_value[can_test_pkg::CRC_CLASSIC_W-1:0];
			end
		end
	end

	chk_capture_clear: assert property (@(posedge sys_clk) disable iff (rst)
		!ctrl.comm_test_enable |=> (classic_crc == '0) && (fd_crc == '0))
		else $error("CRC capture not cleared");
endmodule : crc_capture
`default_nettype wire

// ===== logic/rule_gate.sv
// Decides whether a filtered frame is stored, by source and loopback selector.
// Assumes rule_hit and rule_loopback_select belong to the frame flagged valid.
`timescale 1ns/100ps
`default_nettype none
module rule_gate (
	input  wire logic sys_clk,
	input  wire logic rst,
	test_ctrl_if.sink ctrl,
	input  wire logic frame_valid,
	input  wire logic frame_own,
	input  wire logic rule_hit,
	input  wire logic rule_loopback_select,
	output logic      frame_store
);
	logic next_store;

	always_comb begin
		next_store = 1'b0;
		if (frame_valid && rule_hit) begin
			if (ctrl.self_test) begin
				// Self test overrides mirroring
				next_store = frame_own || !rule_loopback_select;
			end else if (frame_own) begin
				next_store = ctrl.mirror_enable;
			end else begin
				next_store = !rule_loopback_select;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frame_store <= 1'b0;
		end else begin
			frame_store <= next_store;
		end
	end

	chk_lb_other_block: assert property (@(posedge sys_clk) disable iff (rst)
		frame_valid && !frame_own && rule_loopback_select |=> !frame_store)
		else $error("Other-node frame stored by own-only rule");
	chk_self_own_store: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl.self_test && frame_valid && frame_own && rule_hit |=> frame_store)
		else $error("Own frame not stored in self test");
endmodule : rule_gate
`default_nettype wire

// ===== logic/can_test_mode_ctrl.sv
// Test-mode front end of one CAN / CAN FD channel: mode control, CRC capture,
// listen-only, self-test loopback and inter-channel wiring between core and pins.
// Assumes a protocol core on sys_clk and a 2-cycle synchroniser on the rx pin.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module can_test_mode_ctrl #(
	parameter int unsigned SWITCH_CYCLES = can_test_pkg::MODE_SWITCH_CYCLES
) (
	input  wire logic                              sys_clk,
	input  wire logic                              rst,
	input  wire logic [7:0]                        reg_addr,
	input  wire logic [31:0]                       reg_wdata,
	input  wire logic                              reg_write,
	input  wire logic                              reg_read,
	output logic      [31:0]                       reg_rdata,
	input  wire logic                              core_tx,
	output logic                                   core_rx,
	input  wire logic                              core_ack_slot,
	input  wire logic                              core_own_tx,
	output logic                                   core_listen_only,
	input  wire logic                              crc_done,
	input  wire logic                              crc_is_fd,
	input  wire logic [can_test_pkg::CRC_FD_W-1:0] crc_value,
	input  wire logic                              frame_valid,
	input  wire logic                              frame_own,
	input  wire logic                              rule_hit,
	input  wire logic                              rule_loopback_select,
	output logic                                   frame_store,
	input  wire logic                              partner_tx,
	input  wire logic                              bus_rx_pin,
	output logic                                   bus_tx_pin
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [1:0]                           channel_mode_select;
	logic                                 channel_sleep_request;
	logic [1:0]                           test_mode_select;
	logic                                 comm_test_enable;
	logic                                 inter_channel_enable;
	logic                                 mirror_enable;
	can_test_pkg::chan_state_type         state;
	can_test_pkg::chan_state_type         next_state;
	logic [15:0]                          switch_count;
	logic                                 ctrl_wr;
	logic                                 comm_active;
	logic                                 test_live;
	logic                                 listen_only;
	logic                                 self0;
	logic                                 self1;
	logic                                 self_any;
	logic                                 inter_live;
	logic                                 own_ack;
	logic                                 rx_meta;
	logic                                 rx_sync;
	logic [can_test_pkg::CRC_CLASSIC_W-1:0] classic_crc;
	logic [can_test_pkg::CRC_FD_W-1:0]    fd_crc;
	logic [31:0]                          ctrl_image;

	localparam logic [15:0] SWITCH_LAST = 16'(SWITCH_CYCLES - 1);

	// Status code reported for each channel state
	function automatic logic [31:0] status_image(input can_test_pkg::chan_state_type st);
		logic [31:0] img;
		img = 32'h0000_0000;
		case (st)
			can_test_pkg::ST_COMM: begin
				img[can_test_pkg::STS_MODE_LSB +: 2] = can_test_pkg::MODE_COMM;
			end
			can_test_pkg::ST_HALT: begin
				img[can_test_pkg::STS_MODE_LSB +: 2] = can_test_pkg::MODE_HALT;
			end
			can_test_pkg::ST_SLEEP: begin
				img[can_test_pkg::STS_MODE_LSB +: 2] = can_test_pkg::MODE_HALT;
				img[can_test_pkg::STS_SLEEP_BIT]     = 1'b1;
			end
			default: begin
				img[can_test_pkg::STS_MODE_LSB +: 2] = can_test_pkg::MODE_RESET;
			end
		endcase
		return img;
	endfunction : status_image

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	assign ctrl_wr = reg_write && (reg_addr == can_test_pkg::OFS_CTRL);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			channel_mode_select   <= can_test_pkg::MODE_RESET_VAL;
			channel_sleep_request <= 1'b0;
		end else if (ctrl_wr) begin
			channel_mode_select   <= reg_wdata[can_test_pkg::CTRL_MODE_LSB +: 2];
			channel_sleep_request <= reg_wdata[can_test_pkg::CTRL_SLEEP_BIT];
		end
	end

	// Writes outside halt are dropped so a live frame never sees a mode flip
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			test_mode_select     <= can_test_pkg::TMS_RESET_VAL;
			comm_test_enable     <= 1'b0;
			inter_channel_enable <= 1'b0;
			mirror_enable        <= 1'b0;
		end else if (ctrl_wr && (state == can_test_pkg::ST_HALT)) begin
			test_mode_select     <= reg_wdata[can_test_pkg::CTRL_TMS_LSB +: 2];
			comm_test_enable     <= reg_wdata[can_test_pkg::CTRL_CTE_BIT];
			inter_channel_enable <= reg_wdata[can_test_pkg::CTRL_INTER_BIT];
			mirror_enable        <= reg_wdata[can_test_pkg::CTRL_MIRROR_BIT];
		end
	end

	always_comb begin
		ctrl_image = 32'h0000_0000;
		ctrl_image[can_test_pkg::CTRL_MODE_LSB +: 2] = channel_mode_select;
		ctrl_image[can_test_pkg::CTRL_SLEEP_BIT]     = channel_sleep_request;
		ctrl_image[can_test_pkg::CTRL_TMS_LSB +: 2]  = test_mode_select;
		ctrl_image[can_test_pkg::CTRL_CTE_BIT]       = comm_test_enable;
		ctrl_image[can_test_pkg::CTRL_INTER_BIT]     = inter_channel_enable;
		ctrl_image[can_test_pkg::CTRL_MIRROR_BIT]    = mirror_enable;
	end

	// ---------------------------------------------------------------
	// Channel mode tracking
	// ---------------------------------------------------------------
	always_comb begin
		if (channel_sleep_request) begin
			next_state = can_test_pkg::ST_SLEEP;
		end else begin
			case (channel_mode_select)
				can_test_pkg::MODE_COMM:  next_state = can_test_pkg::ST_COMM;
				can_test_pkg::MODE_RESET: next_state = can_test_pkg::ST_RESET;
				can_test_pkg::MODE_HALT:  next_state = can_test_pkg::ST_HALT;
				default:                  next_state = state;
			endcase
		end
	end

	// Status lags the request; software must poll before writing again
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state        <= can_test_pkg::ST_RESET;
			switch_count <= 16'h0000;
		end else if (state != next_state) begin
			if (switch_count >= SWITCH_LAST) begin
				state        <= next_state;
				switch_count <= 16'h0000;
			end else begin
				switch_count <= switch_count + 16'h0001;
			end
		end else begin
			switch_count <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// Test mode decode
	// ---------------------------------------------------------------
	assign comm_active = (state == can_test_pkg::ST_COMM);
	assign test_live   = comm_test_enable && comm_active;
	assign listen_only = test_live && (test_mode_select == can_test_pkg::TMS_LISTEN);
	assign self0       = test_live && (test_mode_select == can_test_pkg::TMS_SELF0);
	assign self1       = test_live && (test_mode_select == can_test_pkg::TMS_SELF1);
	assign self_any    = self0 || self1;
	// Internal loopback wins over the inter-channel wiring
	assign inter_live  = inter_channel_enable && comm_active && !self1;
	assign own_ack     = self_any && core_ack_slot && core_own_tx;
	// Standard test mode (code 00) adds no loopback; only CRC capture, frame mirroring and the inter-channel wiring act on it

	// ---------------------------------------------------------------
	// Pin synchroniser and routing
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_meta <= can_test_pkg::RECESSIVE;
			rx_sync <= can_test_pkg::RECESSIVE;
		end else begin
			rx_meta <= bus_rx_pin;
			rx_sync <= rx_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_tx_pin <= can_test_pkg::RECESSIVE;
		end else if (!comm_active || listen_only || self1 || inter_live) begin
			bus_tx_pin <= can_test_pkg::RECESSIVE;
		end else begin
			bus_tx_pin <= core_tx;
		end
	end

	// Own ack forced dominant so self-test frames complete without a partner
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_rx <= can_test_pkg::RECESSIVE;
		end else if (own_ack) begin
			core_rx <= can_test_pkg::DOMINANT;
		end else if (self1) begin
			core_rx <= core_tx;
		end else if (inter_live) begin
			core_rx <= core_tx & partner_tx;
		end else if (!comm_active) begin
			core_rx <= can_test_pkg::RECESSIVE;
		end else begin
			core_rx <= rx_sync;
		end
	end

	// Tells the core to keep ack, overload and error flags to itself
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_listen_only <= 1'b0;
		end else begin
			core_listen_only <= listen_only;
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	test_ctrl_if ctrl_bus ();
	assign ctrl_bus.comm_test_enable = comm_test_enable;
	assign ctrl_bus.self_test        = self_any;
	assign ctrl_bus.mirror_enable    = mirror_enable;

	crc_capture u_crc (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.ctrl        (ctrl_bus.sink),
		.crc_done    (crc_done),
		.crc_is_fd   (crc_is_fd),
		.crc_value   (crc_value),
		.classic_crc (classic_crc),
		.fd_crc      (fd_crc)
	);

	rule_gate u_gate (
		.sys_clk              (sys_clk),
		.rst                  (rst),
		.ctrl                 (ctrl_bus.sink),
		.frame_valid          (frame_valid),
		.frame_own            (frame_own),
		.rule_hit             (rule_hit),
		.rule_loopback_select (rule_loopback_select),
		.frame_store          (frame_store)
	);

	// ---------------------------------------------------------------
	// Register read port
	// ---------------------------------------------------------------
	// Mask here as well: capture regs clear one cycle after the enable drops
	always_ff @(posedge sys_clk) begin
		if (rst || !reg_read) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				can_test_pkg::OFS_CTRL: begin
					reg_rdata <= ctrl_image;
				end
				can_test_pkg::OFS_STATUS: begin
					reg_rdata <= status_image(state);
				end
				can_test_pkg::OFS_ERR_FLAG: begin
					reg_rdata <= comm_test_enable ? {17'h00000, classic_crc} : 32'h0000_0000;
				end
				can_test_pkg::OFS_FD_CRC: begin
					reg_rdata <= comm_test_enable ? {11'h000, fd_crc} : 32'h0000_0000;
				end
				default: begin
					reg_rdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking chk_clk @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_crc_zero_off: assert property (
		reg_read && !comm_test_enable &&
		((reg_addr == can_test_pkg::OFS_ERR_FLAG) || (reg_addr == can_test_pkg::OFS_FD_CRC))
		|=> reg_rdata == 32'h0000_0000)
		else $error("CRC read nonzero with testing off");

	chk_classic_crc_read: assert property (
		crc_done && !crc_is_fd && comm_test_enable && !ctrl_wr ##1
		reg_read && (reg_addr == can_test_pkg::OFS_ERR_FLAG) && comm_test_enable && !crc_done
		|=> reg_rdata == {17'h00000, $past(crc_value[14:0], 2)})
		else $error("Classical CRC not readable");

	chk_fd_crc_read: assert property (
		crc_done && crc_is_fd && comm_test_enable && !ctrl_wr ##1
		reg_read && (reg_addr == can_test_pkg::OFS_FD_CRC) && comm_test_enable && !crc_done
		|=> reg_rdata == {11'h000, $past(crc_value, 2)})
		else $error("FD CRC not readable");

	chk_listen_recessive: assert property (
		listen_only |=> bus_tx_pin == can_test_pkg::RECESSIVE)
		else $error("Listen-only drove dominant");

	chk_listen_receive: assert property (
		listen_only && !own_ack && !inter_live |=> core_rx == $past(rx_sync))
		else $error("Listen-only lost bus data");

	chk_self_ack: assert property (
		self_any && core_ack_slot && core_own_tx |=> core_rx == can_test_pkg::DOMINANT)
		else $error("Own acknowledge missing");

	chk_internal_loop: assert property (
		self1 && !own_ack |=> core_rx == $past(core_tx))
		else $error("Internal loopback broken");

	chk_st1_isolated: assert property (
		self1 [*2] |=> bus_tx_pin == can_test_pkg::RECESSIVE && $stable(bus_tx_pin))
		else $error("Pin not held recessive in self test 1");

	chk_test_bits_halt: assert property (
		$changed(test_mode_select) || $changed(comm_test_enable)
		|-> $past(state) == can_test_pkg::ST_HALT)
		else $error("Test settings changed outside halt");

	chk_mode_switch_time: assert property (
		$changed(state) |-> $past(switch_count) == SWITCH_LAST)
		else $error("Mode reported at wrong time");

	chk_ext_loop_tx: assert property (
		self0 && !inter_live |=> bus_tx_pin == $past(core_tx))
		else $error("External loopback tx not driven");

endmodule : can_test_mode_ctrl
`default_nettype wire

// ===== verif/can_bus_node.sv
// Bus model: one transceiver plus one other node on a wired-AND CAN bus.
// Assumes the bus is pulled recessive when nobody drives dominant.
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
	input  wire logic bus_tx_pin,
	input  wire logic node_tx,
	output logic      bus_rx_pin
);
	// Dominant from either party wins, so own frames come back through the transceiver
	assign bus_rx_pin = bus_tx_pin & node_tx;
endmodule : can_bus_node
`default_nettype wire

// ===== verif/can_test_mode_ctrl_tb.sv
// Self-checking bench for the CAN channel test-mode block.
// Assumes the bus node model on the pins and a 10 MHz sys_clk.
`timescale 1ns/100ps
`default_nettype none
module can_test_mode_ctrl_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic        core_tx = 1'b1;
	logic        core_rx;
	logic        core_ack_slot = 1'b0;
	logic        core_own_tx = 1'b0;
	logic        core_listen_only;
	logic        crc_done = 1'b0;
	logic        crc_is_fd = 1'b0;
	logic [20:0] crc_value = 21'h0;
	logic        frame_valid = 1'b0;
	logic        frame_own = 1'b0;
	logic        rule_hit = 1'b0;
	logic        rule_loopback_select = 1'b0;
	logic        frame_store;
	logic        partner_tx = 1'b1;
	logic        node_tx = 1'b1;
	logic        bus_rx_pin;
	logic        bus_tx_pin;
	logic        rd_seen = 1'b0;
	logic        inter_on = 1'b0;
	logic [31:0] cur = 32'h0;
	logic [31:0] exp_q[$];
	int          num_errors = 0;
	int          checked = 0;

	can_test_mode_ctrl #(.SWITCH_CYCLES(4)) u_can_test_mode_ctrl (.sys_clk, .rst, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .core_tx, .core_rx, .core_ack_slot, .core_own_tx, .core_listen_only,
		.crc_done, .crc_is_fd, .crc_value, .frame_valid, .frame_own, .rule_hit, .rule_loopback_select,
		.frame_store, .partner_tx, .bus_rx_pin, .bus_tx_pin);
	can_bus_node u_can_bus_node (.bus_tx_pin, .node_tx, .bus_rx_pin);

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	// ---------------------------------------------------------------
	// Checking
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_seen <= reg_read;
		if (rd_seen)
			chk(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~reg_rdata);
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_read <= 1'b0;
	endtask : rd

	task automatic settle(input logic [1:0] m);
		repeat (6) @(posedge sys_clk);
		rd(can_test_pkg::OFS_STATUS, {30'h0, m});
	endtask : settle

	// Test fields are only touched while the channel reports halt
	task automatic cfg(input logic [1:0] tms, input logic cte, input logic mir);
		wr(can_test_pkg::OFS_CTRL, cur | 32'h2);
		settle(can_test_pkg::MODE_HALT);
		cur = {11'h0, mir, inter_on, cte, tms, 16'h0};
		wr(can_test_pkg::OFS_CTRL, cur | 32'h2);
		wr(can_test_pkg::OFS_CTRL, cur);
		settle(can_test_pkg::MODE_COMM);
		rd(can_test_pkg::OFS_CTRL, cur);
	endtask : cfg

	task automatic frame_crc(input logic fd);
		logic [20:0] v;
		v = 21'($urandom);
		@(posedge sys_clk);
		crc_done <= 1'b1;
		crc_is_fd <= fd;
		crc_value <= v;
		// Read right behind the capture edge
		@(posedge sys_clk);
		crc_done <= 1'b0;
		reg_read <= 1'b1;
		reg_addr <= fd ? can_test_pkg::OFS_FD_CRC : can_test_pkg::OFS_ERR_FLAG;
		exp_q.push_back(!cur[18] ? 32'h0 : fd ? {11'h0, v} : {17'h0, v[14:0]});
		@(posedge sys_clk);
		reg_read <= 1'b0;
	endtask : frame_crc

	task automatic pins(input logic tx, input logic nd, input logic erx, input logic etx);
		@(posedge sys_clk);
		core_tx <= tx;
		node_tx <= nd;
		repeat (6) @(posedge sys_clk);
		#1;
		chk(32'(core_rx), 32'(erx));
		chk(32'(bus_tx_pin), 32'(etx));
	endtask : pins

	task automatic ack;
		@(posedge sys_clk);
		core_tx <= 1'b1;
		node_tx <= 1'b1;
		// Recessive must reach core_rx first, so only the forced ack can pull it low
		repeat (4) @(posedge sys_clk);
		core_ack_slot <= 1'b1;
		core_own_tx <= 1'b1;
		@(posedge sys_clk);
		core_ack_slot <= 1'b0;
		core_own_tx <= 1'b0;
		#1 chk(32'(core_rx), 32'h0);
	endtask : ack

	task automatic gate(input logic [2:0] c, input logic e);
		@(posedge sys_clk);
		frame_valid <= 1'b1;
		frame_own <= c[0];
		rule_hit <= c[1];
		rule_loopback_select <= c[2];
		@(posedge sys_clk);
		frame_valid <= 1'b0;
		#1 chk(32'(frame_store), 32'(e));
	endtask : gate

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h38e1));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(can_test_pkg::OFS_CTRL, 32'h1);
		rd(can_test_pkg::OFS_STATUS, 32'h1);
		rd(8'h10, 32'h0);
		$display("reset values done");
		cfg(can_test_pkg::TMS_STANDARD, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
			frame_crc(i[0]);
		pins(1'b0, 1'b1, 1'b0, 1'b0);
		chk(32'(core_listen_only), 32'h0);
		for (int i = 0; i < 8; i++)
			gate(i[2:0], i[1] & ~i[2] & ~i[0]);
		wr(can_test_pkg::OFS_CTRL, cur | 32'h0001_0000);
		rd(can_test_pkg::OFS_CTRL, cur);
		cfg(can_test_pkg::TMS_STANDARD, 1'b0, 1'b0);
		frame_crc(1'b0);
		frame_crc(1'b1);
		$display("standard test done");
		cfg(can_test_pkg::TMS_LISTEN, 1'b1, 1'b0);
		pins(1'b0, 1'b0, 1'b0, 1'b1);
		chk(32'(core_listen_only), 32'h1);
		$display("listen-only done");
		cfg(can_test_pkg::TMS_SELF0, 1'b1, 1'b0);
		pins(1'b0, 1'b1, 1'b0, 1'b0);
		ack();
		cfg(can_test_pkg::TMS_SELF1, 1'b1, 1'b1);
		pins(1'b0, 1'b1, 1'b0, 1'b1);
		pins(1'b1, 1'b0, 1'b1, 1'b1);
		ack();
		for (int i = 0; i < 8; i++)
			gate(i[2:0], i[1] & (i[0] | ~i[2]));
		$display("self test done");
		inter_on = 1'b1;
		cfg(can_test_pkg::TMS_STANDARD, 1'b1, 1'b0);
		@(posedge sys_clk);
		partner_tx <= 1'b0;
		pins(1'b1, 1'b1, 1'b0, 1'b1);
		@(posedge sys_clk);
		partner_tx <= 1'b1;
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		$display("inter-channel done");
		repeat (3) @(posedge sys_clk);
		conclude();
	end
endmodule : can_test_mode_ctrl_tb
`default_nettype wire
